/* File: design/pfsd_pkg.sv */
package pfsd_pkg;

  // Data pin mode encodings
  typedef enum logic [2:0] {
    PFSD_MODE_EXT_MEM = 3'h0,
    PFSD_MODE_RSV1 = 3'h1,
    PFSD_MODE_RSV2 = 3'h2,
    PFSD_MODE_FLAGS = 3'h3,
    PFSD_MODE_RSV4 = 3'h4,
    PFSD_MODE_ACQ = 3'h5,
    PFSD_MODE_RSV6 = 3'h6,
    PFSD_MODE_TRISTATE = 3'h7
  } pfsd_pin_mode_e;

  // Boot sources
  typedef enum logic [2:0] {
    PFSD_BOOT_SPI_SLAVE = 3'h0,
    PFSD_BOOT_SPI_MASTER = 3'h1,
    PFSD_BOOT_ASYNC_MEM = 3'h2,
    PFSD_BOOT_RSV3 = 3'h3,
    PFSD_BOOT_LINK0 = 3'h4,
    PFSD_BOOT_RSV5 = 3'h5,
    PFSD_BOOT_RSV6 = 3'h6,
    PFSD_BOOT_RSV7 = 3'h7
  } pfsd_boot_e;

  typedef enum logic [1:0] {
    PFSD_RATIO_6 = 2'h0,
    PFSD_RATIO_32 = 2'h1,
    PFSD_RATIO_16 = 2'h2,
    PFSD_RATIO_RSV = 2'h3
  } pfsd_ratio_code_e;

  localparam int PFSD_ADDR_W = 24;
  localparam int PFSD_DATA_W = 8;
  localparam int PFSD_FLAG_W = 16;
  localparam int PFSD_UPPER_LSB = 8;
  localparam logic [5:0] PFSD_MULT_6 = 6'h06;
  localparam logic [5:0] PFSD_MULT_16 = 6'h10;
  localparam logic [5:0] PFSD_MULT_32 = 6'h20;
  localparam logic [5:0] PFSD_MULT_NONE = 6'h00;
  localparam int PFSD_LOCK_CYCLES = 4096;
  localparam int PFSD_LOCK_W = 13;
  localparam logic [PFSD_LOCK_W-1:0] PFSD_LOCK_ONE = 13'h0001;

  // Pin bundle: per-pin out/enable
  typedef struct packed {
    logic [PFSD_ADDR_W-1:0] addr_out;
    logic [PFSD_ADDR_W-1:0] addr_oe;
    logic [PFSD_DATA_W-1:0] data_out;
    logic [PFSD_DATA_W-1:0] data_oe;
  } pfsd_pins_s;

  typedef struct packed {
    pfsd_boot_e boot;
    pfsd_ratio_code_e ratio;
  } pfsd_straps_s;

endpackage : pfsd_pkg

/* File: design/pfsd_strap_latch.sv */
`timescale 1ns/1ps
module pfsd_strap_latch (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] boot_select_straps,
  input wire logic [1:0] clock_ratio_straps,
  output pfsd_pkg::pfsd_straps_s straps,
  output logic straps_valid
);
  import pfsd_pkg::*;

  typedef struct packed {
    logic [2:0] boot_s1;
    logic [1:0] ratio_s1;
    logic [2:0] boot_s2;
    logic [1:0] ratio_s2;
    pfsd_straps_s held;
    logic valid;
  } pfsd_latch_s;

  pfsd_latch_s st_reg;
  pfsd_latch_s st_next;

  // Reset is asynchronous, so straps cannot be loaded by it; they track
  // the pins through a synchroniser while reset holds, then freeze.
  logic in_reset_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      in_reset_reg <= 1'b1;
    end else begin
      in_reset_reg <= 1'b0;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.boot_s1 = boot_select_straps;
    st_next.ratio_s1 = clock_ratio_straps;
    st_next.boot_s2 = st_reg.boot_s1;
    st_next.ratio_s2 = st_reg.ratio_s1;
    if (in_reset_reg) begin
      st_next.held.boot = pfsd_boot_e'(st_reg.boot_s2);
      st_next.held.ratio = pfsd_ratio_code_e'(st_reg.ratio_s2);
      st_next.valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  assign straps = st_reg.held;
  assign straps_valid = st_reg.valid;

  property p_strap_hold;
    @(posedge sys_clk) disable iff (!resetn)
      (!in_reset_reg && $past(!in_reset_reg)) |-> $stable(st_reg.held);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("Strap latch changed");

endmodule : pfsd_strap_latch

/* File: design/pfsd_top.sv */
// Behaviour
// - A 3-bit data pin mode field in system control selects shared pin function.
// - Mode 000: 24 address pins drive memory address, 8 data pins bidirectional.
// - Mode 011: upper 16 address pins flag/PWM 15-0, rest flags 15-0.
// - Mode 101: address pins are acquisition inputs; data pins are flags 7-0.
// - Mode 111 three-states all shared pins; reserved modes must not be used.
// - Boot strap: 000 SPI slave, 001 SPI master, 100 link port 0.
// - Boot strap 010 boots from byte-wide flash over async memory interface.
// - Ratio strap: 00 gives 6:1, 01 32:1, 10 16:1; 11 reserved.
// - After reset release wait 4096 reference clocks, then start at reset vector.
`timescale 1ns/1ps
module pfsd_top #(
  parameter int LOCK_CYCLES = pfsd_pkg::PFSD_LOCK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] data_pin_mode,
  input wire logic mode_write,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wdata_oe,
  input wire logic [15:0] flag_pwm_out,
  input wire logic [15:0] flag_pwm_oe,
  input wire logic [15:0] flag_out,
  input wire logic [15:0] flag_oe,
  input wire logic [23:0] ext_mem_address_pins_in,
  input wire logic [7:0] ext_mem_data_pins_in,
  input wire logic [2:0] boot_select_straps,
  input wire logic [1:0] clock_ratio_straps,
  output logic [23:0] ext_mem_address_pins_out,
  output logic [23:0] ext_mem_address_pins_oe,
  output logic [7:0] ext_mem_data_pins_out,
  output logic [7:0] ext_mem_data_pins_oe,
  output logic [7:0] mem_rdata,
  output logic [15:0] flag_pwm_in,
  output logic [15:0] flag_in,
  output logic [23:0] acq_port_in,
  output pfsd_pkg::pfsd_pin_mode_e system_control_register,
  output pfsd_pkg::pfsd_boot_e boot_source,
  output logic boot_async_mem_8bit,
  output logic [5:0] core_clock_multiplier,
  output logic core_run
);
  import pfsd_pkg::*;

  localparam logic [PFSD_LOCK_W-1:0] LOCK_LAST = PFSD_LOCK_W'(LOCK_CYCLES);

  typedef struct packed {
    pfsd_pin_mode_e mode;
    pfsd_pins_s pins;
    logic [PFSD_ADDR_W-1:0] a_s1;
    logic [PFSD_ADDR_W-1:0] a_s2;
    logic [PFSD_DATA_W-1:0] d_s1;
    logic [PFSD_DATA_W-1:0] d_s2;
    logic [PFSD_DATA_W-1:0] rdata;
    logic [PFSD_FLAG_W-1:0] fpwm_in;
    logic [PFSD_FLAG_W-1:0] flg_in;
    logic [PFSD_ADDR_W-1:0] acq_in;
    pfsd_boot_e boot;
    logic boot_mem8;
    logic [5:0] mult;
    logic [PFSD_LOCK_W-1:0] lock_cnt;
    logic run;
  } pfsd_state_s;

  pfsd_state_s st_reg;
  pfsd_state_s st_next;
  pfsd_straps_s straps;
  logic straps_valid;

  pfsd_strap_latch u_strap_latch (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .boot_select_straps(boot_select_straps),
    .clock_ratio_straps(clock_ratio_straps),
    .straps(straps),
    .straps_valid(straps_valid)
  );

  always_comb begin
    st_next = st_reg;
    // Pin inputs pass two flops before any decode
    st_next.a_s1 = ext_mem_address_pins_in;
    st_next.a_s2 = st_reg.a_s1;
    st_next.d_s1 = ext_mem_data_pins_in;
    st_next.d_s2 = st_reg.d_s1;
    if (mode_write) begin
      st_next.mode = pfsd_pin_mode_e'(data_pin_mode);
    end
    st_next.pins = '0;
    st_next.rdata = '0;
    st_next.fpwm_in = '0;
    st_next.flg_in = '0;
    st_next.acq_in = '0;
    case (st_reg.mode)
      PFSD_MODE_EXT_MEM: begin
        st_next.pins.addr_out = mem_addr;
        st_next.pins.addr_oe = '1;
        st_next.pins.data_out = mem_wdata;
        st_next.pins.data_oe = {PFSD_DATA_W{mem_wdata_oe}};
        st_next.rdata = st_reg.d_s2;
      end
      PFSD_MODE_FLAGS: begin
        st_next.pins.addr_out = {flag_pwm_out, flag_out[PFSD_UPPER_LSB-1:0]};
        st_next.pins.addr_oe = {flag_pwm_oe, flag_oe[PFSD_UPPER_LSB-1:0]};
        st_next.pins.data_out = flag_out[PFSD_FLAG_W-1:PFSD_UPPER_LSB];
        st_next.pins.data_oe = flag_oe[PFSD_FLAG_W-1:PFSD_UPPER_LSB];
        st_next.fpwm_in = st_reg.a_s2[PFSD_ADDR_W-1:PFSD_UPPER_LSB];
        st_next.flg_in = {st_reg.d_s2, st_reg.a_s2[PFSD_UPPER_LSB-1:0]};
      end
      PFSD_MODE_ACQ: begin
        // Address pins stay undriven: acquisition port is input only
        st_next.acq_in = st_reg.a_s2;
        st_next.pins.data_out = flag_out[PFSD_DATA_W-1:0];
        st_next.pins.data_oe = flag_oe[PFSD_DATA_W-1:0];
        st_next.flg_in = {{(PFSD_FLAG_W-PFSD_DATA_W){1'b0}}, st_reg.d_s2};
      end
      default: begin
        // Three-state; reserved codes also float, the safest pin state
        st_next.pins = '0;
      end
    endcase
    st_next.boot = straps.boot;
    st_next.boot_mem8 = (straps.boot == PFSD_BOOT_ASYNC_MEM);
    case (straps.ratio)
      PFSD_RATIO_6: st_next.mult = PFSD_MULT_6;
      PFSD_RATIO_32: st_next.mult = PFSD_MULT_32;
      PFSD_RATIO_16: st_next.mult = PFSD_MULT_16;
      default: st_next.mult = PFSD_MULT_NONE;
    endcase
    if (straps_valid && !st_reg.run) begin
      if (st_reg.lock_cnt == LOCK_LAST) begin
        st_next.run = 1'b1;
      end else begin
        st_next.lock_cnt = st_reg.lock_cnt + PFSD_LOCK_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.mode <= PFSD_MODE_EXT_MEM;
      st_reg.boot <= PFSD_BOOT_SPI_SLAVE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ext_mem_address_pins_out = st_reg.pins.addr_out;
  assign ext_mem_address_pins_oe = st_reg.pins.addr_oe;
  assign ext_mem_data_pins_out = st_reg.pins.data_out;
  assign ext_mem_data_pins_oe = st_reg.pins.data_oe;
  assign mem_rdata = st_reg.rdata;
  assign flag_pwm_in = st_reg.fpwm_in;
  assign flag_in = st_reg.flg_in;
  assign acq_port_in = st_reg.acq_in;
  assign system_control_register = st_reg.mode;
  assign boot_source = st_reg.boot;
  assign boot_async_mem_8bit = st_reg.boot_mem8;
  assign core_clock_multiplier = st_reg.mult;
  assign core_run = st_reg.run;

  property p_ext_mem_addr;
    @(posedge sys_clk) disable iff (!resetn)
      (st_reg.mode == PFSD_MODE_EXT_MEM) |=> (ext_mem_address_pins_oe == '1
        && ext_mem_address_pins_out == $past(mem_addr));
  endproperty
  a_ext_mem_addr: assert property (p_ext_mem_addr) else $error("Address not driven");

  property p_flags_map;
    @(posedge sys_clk) disable iff (!resetn)
      (st_reg.mode == PFSD_MODE_FLAGS) |=>
        (ext_mem_address_pins_out[PFSD_ADDR_W-1:PFSD_UPPER_LSB] == $past(flag_pwm_out));
  endproperty
  a_flags_map: assert property (p_flags_map) else $error("Flag/PWM map wrong");

  property p_acq_input;
    @(posedge sys_clk) disable iff (!resetn)
      (st_reg.mode == PFSD_MODE_ACQ) |=> (ext_mem_address_pins_oe == '0);
  endproperty
  a_acq_input: assert property (p_acq_input) else $error("Acquisition pins driven");

  property p_tristate;
    @(posedge sys_clk) disable iff (!resetn)
      (st_reg.mode == PFSD_MODE_TRISTATE) |=>
        (ext_mem_address_pins_oe == '0 && ext_mem_data_pins_oe == '0);
  endproperty
  a_tristate: assert property (p_tristate) else $error("Pins not three-stated");

  // Write reaches the pins in two steps: mode register, then pin register
  sequence s_float_write;
    mode_write && (data_pin_mode == PFSD_MODE_TRISTATE) ##1 !mode_write;
  endsequence

  sequence s_float_pins;
    (ext_mem_address_pins_oe == '0) && (ext_mem_data_pins_oe == '0);
  endsequence

  property p_float_after_write;
    @(posedge sys_clk) disable iff (!resetn)
      s_float_write |=> s_float_pins;
  endproperty
  a_float_after_write: assert property (p_float_after_write) else $error("Float write not applied");

  property p_mode_write;
    @(posedge sys_clk) disable iff (!resetn)
      mode_write |=> (system_control_register == $past(data_pin_mode));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Mode not stored");

  property p_ratio;
    @(posedge sys_clk) disable iff (!resetn)
      (straps.ratio == PFSD_RATIO_32) |=> (core_clock_multiplier == PFSD_MULT_32);
  endproperty
  a_ratio: assert property (p_ratio) else $error("Ratio decode wrong");

  property p_boot8;
    @(posedge sys_clk) disable iff (!resetn)
      (straps.boot == PFSD_BOOT_ASYNC_MEM) |=> boot_async_mem_8bit;
  endproperty
  a_boot8: assert property (p_boot8) else $error("Flash boot missing");

  property p_boot_src;
    @(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> (boot_source == $past(straps.boot));
  endproperty
  a_boot_src: assert property (p_boot_src) else $error("Boot source wrong");

  property p_no_early_run;
    @(posedge sys_clk) disable iff (!resetn)
      (st_reg.lock_cnt < LOCK_LAST) |-> !core_run;
  endproperty
  a_no_early_run: assert property (p_no_early_run) else $error("Ran before lock");

endmodule : pfsd_top

/* File: test/pfsd_pin_partner.sv */
`timescale 1ns/1ps
module pfsd_pin_partner (
  input wire logic sys_clk,
  input wire logic [31:0] dev_out,
  input wire logic [31:0] dev_oe,
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_en,
  output logic [31:0] pin
);
  logic [31:0] last_reg = 32'h00000000;
  always_ff @(posedge sys_clk) begin
    last_reg <= pin;
  end
  // Undriven pins toggle so a stale value never reads as a match
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pin[i] = dev_oe[i] ? dev_out[i] : (ext_en[i] ? ext_val[i] : ~last_reg[i]);
    end
  end
endmodule : pfsd_pin_partner

/* File: test/pin_function_and_strap_decode_bench.sv */
`timescale 1ns/1ps
module pin_function_and_strap_decode_bench;
  import pfsd_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] data_pin_mode = 3'h0;
  logic mode_write = 1'b0;
  logic [23:0] mem_addr = 24'h000000;
  logic [7:0] mem_wdata = 8'h00;
  logic mem_wdata_oe = 1'b0;
  logic [15:0] fp_out = 16'h0000;
  logic [15:0] fp_oe = 16'h0000;
  logic [15:0] f_out = 16'h0000;
  logic [15:0] f_oe = 16'h0000;
  logic [2:0] boot_sel = 3'h0;
  logic [1:0] ratio_sel = 2'h0;
  logic [31:0] ext_val = 32'h00000000;
  logic [31:0] ext_en = 32'h00000000;
  logic [31:0] pin;
  logic [23:0] ap_out, ap_oe, acq;
  logic [7:0] dp_out, dp_oe, rdata;
  logic [15:0] fp_in, f_in;
  pfsd_pin_mode_e mode_q;
  pfsd_boot_e boot_q;
  logic async8, run;
  logic [5:0] mult;
  int n_errors = 0;
  int n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  pfsd_top #(.LOCK_CYCLES(16)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .data_pin_mode(data_pin_mode), .mode_write(mode_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wdata_oe(mem_wdata_oe), .flag_pwm_out(fp_out),
    .flag_pwm_oe(fp_oe), .flag_out(f_out), .flag_oe(f_oe),
    .ext_mem_address_pins_in(pin[31:8]), .ext_mem_data_pins_in(pin[7:0]),
    .boot_select_straps(boot_sel), .clock_ratio_straps(ratio_sel),
    .ext_mem_address_pins_out(ap_out), .ext_mem_address_pins_oe(ap_oe),
    .ext_mem_data_pins_out(dp_out), .ext_mem_data_pins_oe(dp_oe), .mem_rdata(rdata),
    .flag_pwm_in(fp_in), .flag_in(f_in), .acq_port_in(acq),
    .system_control_register(mode_q), .boot_source(boot_q),
    .boot_async_mem_8bit(async8), .core_clock_multiplier(mult), .core_run(run));
  pfsd_pin_partner partner (.sys_clk(sys_clk), .dev_out({ap_out, dp_out}),
    .dev_oe({ap_oe, dp_oe}), .ext_val(ext_val), .ext_en(ext_en), .pin(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic do_reset(input logic [2:0] b, input logic [1:0] r);
    boot_sel = b;
    ratio_sel = r;
    resetn = 1'b0;
    cyc(4);
    resetn = 1'b1;
  endtask : do_reset
  task automatic set_mode(input logic [2:0] m);
    data_pin_mode = m;
    mode_write = 1'b1;
    cyc(1);
    mode_write = 1'b0;
    cyc(2);
    chk(mode_q, m);
  endtask : set_mode
  task automatic t_reset_lock();
    int n;
    do_reset(3'h0, 2'h0);
    chk(mode_q, PFSD_MODE_EXT_MEM);
    n = 0;
    while (run !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(n >= 16 && n <= 18, 1);
  endtask : t_reset_lock
  task automatic t_straps();
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [5:0] mults [3] = '{6'h06, 6'h20, 6'h10};
    for (int i = 0; i < 4; i++) begin
      do_reset(codes[i], 2'(i % 3));
      cyc(2);
      // Straps move after release and must be ignored
      boot_sel = ~codes[i];
      ratio_sel = ~2'(i % 3);
      cyc(3);
      chk(boot_q, codes[i]);
      chk(async8, codes[i] == 3'h2);
      chk(mult, mults[i % 3]);
    end
  endtask : t_straps
  task automatic t_mem();
    set_mode(3'h0);
    mem_addr = 24'hA5C3E1;
    mem_wdata = 8'h5A;
    mem_wdata_oe = 1'b1;
    cyc(2);
    chk({ap_out, ap_oe}, {24'hA5C3E1, 24'hFFFFFF});
    chk({dp_out, dp_oe}, {8'h5A, 8'hFF});
    mem_wdata_oe = 1'b0;
    ext_en = 32'h000000FF;
    ext_val = 32'h0000003C;
    cyc(6);
    chk({dp_oe, rdata}, {8'h00, 8'h3C});
  endtask : t_mem
  task automatic t_flags();
    fp_out = 16'h1234;
    fp_oe = 16'hFFFF;
    f_out = 16'hABCD;
    f_oe = 16'hFF00;
    ext_en = 32'h0000FF00;
    ext_val = 32'h00005A00;
    set_mode(3'h3);
    chk(ap_out, {16'h1234, 8'hCD});
    chk(ap_oe, {16'hFFFF, 8'h00});
    chk({dp_out, dp_oe}, {8'hAB, 8'hFF});
    cyc(4);
    chk(f_in[7:0], 8'h5A);
    chk(f_in[15:8], 8'hAB);
    chk(fp_in, 16'h1234);
  endtask : t_flags
  task automatic t_acq();
    f_out = 16'h0096;
    f_oe = 16'h00FF;
    ext_en = 32'hFFFFFF00;
    ext_val = 32'hC0FFEE00;
    set_mode(3'h5);
    cyc(4);
    chk({ap_oe, acq}, {24'h000000, 24'hC0FFEE});
    chk({dp_out, dp_oe}, {8'h96, 8'hFF});
    chk({fp_in, f_in}, {16'h0000, 16'h0096});
  endtask : t_acq
  task automatic t_tristate();
    logic [2:0] codes [5] = '{3'h7, 3'h1, 3'h2, 3'h4, 3'h6};
    ext_en = 32'h00000000;
    mem_wdata_oe = 1'b1;
    f_oe = 16'hFFFF;
    for (int i = 0; i < 5; i++) begin
      set_mode(codes[i]);
      chk({ap_oe, dp_oe}, 32'h00000000);
    end
  endtask : t_tristate
  task automatic complete_run();
    $display("Checks made %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end
  initial begin
    t_reset_lock();
    t_straps();
    t_mem();
    t_flags();
    t_acq();
    t_tristate();
    complete_run();
  end
endmodule : pin_function_and_strap_decode_bench
